// [usbef_regs.vh]
// Register offsets, field positions and reset values of the endpoint flag block.
// What this block does
// - Control endpoint: valid SETUP in current bank sets setup-received flag.
// - Write-one clear of setup-received acknowledges it and frees its bank.
// - Setup bit reads zero on bulk/interrupt, means underflow on isochronous.
// - Control endpoint: OUT data/status packet sets OUT flag; clearing frees bank.
// - Non-control OUT: full bank sets OUT flag with release bit; clear only acknowledges.
// - Releasing a bank advances to next bank; flags follow that bank's state.
// - Control endpoint: free bank sets IN-ready; clearing it sends the packet.
// - Non-control IN: free bank sets IN-ready with release; release clear transmits.
// - OUT flag zero on non-control IN; IN-ready zero on non-control OUT.
// - Write-only status-clear word per endpoint; ones clear flags; reads zero.
// - Write-only status-set word forces flags and busy-bank trigger bit 12.
// - Stall request bit 19: set by write, cleared by SETUP or clear write.
// - Toggle reset set forces DATA0 next packet; bit 18 clears itself.
// - NYET suppression bit 17 answers ACK instead of NYET while set.
// - DMA pause bit 16 pauses channel n on any pending endpoint source.
// - Bank-tied source lets running transfer finish, withholds next request.
// - Sources not tied to a bank withdraw the DMA request at once.
// - Control endpoints read bank release and rw-allowed as zero.
// - Endpoint interrupt asserts when a flag and its enable are both one.
// - Enables set by set-register ones, cleared by clear-register ones.
// - OUT release clear frees current bank and switches to the next.
`ifndef USBEF_REGS_VH
`define USBEF_REGS_VH
// Per-endpoint register bases; endpoint n adds n words.
`define USBEF_CFG_BASE    12'h100
`define USBEF_STA_BASE    12'h120
`define USBEF_STCLR_BASE  12'h160
`define USBEF_STSET_BASE  12'h190
`define USBEF_CON_BASE    12'h1c0
`define USBEF_CONSET_BASE 12'h1f0
`define USBEF_CONCLR_BASE 12'h220
// Status flag bit positions.
`define USBEF_IN_READY    0
`define USBEF_OUT_RX      1
`define USBEF_SETUP_RX    2
`define USBEF_NAK_OUT     3
`define USBEF_NAK_IN      4
`define USBEF_OVERFLOW    5
`define USBEF_STALLED     6
`define USBEF_SHORT_PKT   7
`define USBEF_BUSY_FORCE  12
// Status read fields.
`define USBEF_BUSY_LSB    16
`define USBEF_CUR_LSB     18
`define USBEF_RW_ALLOWED  20
// Control bit positions.
`define USBEF_BUSY_IRQ_EN 12
`define USBEF_BANK_REL    14
`define USBEF_DMA_PAUSE   16
`define USBEF_NYET_SUPP   17
`define USBEF_TOGGLE_RST  18
`define USBEF_STALL_REQ   19
// Configuration fields and endpoint types.
`define USBEF_CFG_DIR     2
`define USBEF_CFG_NB_LSB  3
`define USBEF_TYPE_CTRL   2'h0
`define USBEF_TYPE_ISO    2'h1
`define USBEF_TYPE_BULK   2'h2
`define USBEF_TYPE_INTR   2'h3
// Reset values.
`define USBEF_CFG_RESET   5'h08
`define USBEF_ZERO_RESET  8'h00
`endif

// [usbef_bank.v]
// Bank occupancy tracker for one endpoint: busy count and current bank.
`timescale 1ns/10ps
module usbef_bank (
  // Clock and reset.
  input  wire       clk_in,
  input  wire       reset_n_in,
  // Endpoint setup.
  input  wire [1:0] nbanks_in,
  input  wire       dir_in_in,
  // Bank events.
  input  wire       core_evt_in,
  input  wire       release_in,
  // State.
  output reg  [1:0] busy_out,
  output reg  [1:0] cur_out,
  output reg        ready_out,
  output wire       rise_out
);
  reg  [1:0] busy_next;
  reg  [1:0] cur_next;
  wire [1:0] nb;
  wire       ready_next;

  // A zero bank count is treated as a single bank.
  assign nb = (nbanks_in == 2'h0) ? 2'h1 : nbanks_in;

  // OUT counts banks the host filled; IN counts banks software filled.
  always @* begin
    busy_next = busy_out;
    if (dir_in_in) begin
      if (release_in && !core_evt_in && busy_out != nb)
        busy_next = busy_out + 2'h1;
      else if (core_evt_in && !release_in && busy_out != 2'h0)
        busy_next = busy_out - 2'h1;
    end else begin
      if (core_evt_in && !release_in && busy_out != nb)
        busy_next = busy_out + 2'h1;
      else if (release_in && !core_evt_in && busy_out != 2'h0)
        busy_next = busy_out - 2'h1;
    end
    cur_next = cur_out;
    if (release_in)
      cur_next = (cur_out + 2'h1 >= nb) ? 2'h0 : cur_out + 2'h1;
  end

  // The current bank belongs to software when it holds data (OUT) or is free (IN).
  assign ready_next = dir_in_in ? (busy_next != nb) : (busy_next != 2'h0);
  // A fresh bank after a release re-arms the flags even when the state is unchanged.
  assign rise_out   = ready_next && (!ready_out || release_in);

  // Occupancy registers.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      busy_out  <= 2'h0;
      cur_out   <= 2'h0;
      ready_out <= 1'b0;
    end else begin
      busy_out  <= busy_next;
      cur_out   <= cur_next;
      ready_out <= ready_next;
    end
  end
endmodule // usbef_bank

// [usbef_flags.v]
// Endpoint status and control flags for eight endpoints behind an APB slave.
`timescale 1ns/10ps
`include "usbef_regs.vh"
module usbef_flags #(
  parameter NEP = 8
) (
  // Clock and reset.
  input  wire            clk_in,
  input  wire            reset_n_in,
  // APB slave.
  input  wire            psel_in,
  input  wire            penable_in,
  input  wire            pwrite_in,
  input  wire [11:0]     paddr_in,
  input  wire [31:0]     pwdata_in,
  output reg  [31:0]     prdata_out,
  output wire            pready_out,
  output wire            pslverr_out,
  // USB core events, one bit per endpoint, one-cycle pulses.
  input  wire [NEP-1:0]  setup_rx_in,
  input  wire [NEP-1:0]  out_rx_in,
  input  wire [NEP-1:0]  in_sent_in,
  input  wire [NEP-1:0]  nak_in_evt_in,
  input  wire [NEP-1:0]  nak_out_evt_in,
  input  wire [NEP-1:0]  underflow_evt_in,
  input  wire [NEP-1:0]  overflow_evt_in,
  input  wire [NEP-1:0]  stalled_evt_in,
  input  wire [NEP-1:0]  short_evt_in,
  // DMA channel n is mid-transfer on a bank.
  input  wire [NEP-1:0]  dma_busy_in,
  // Endpoint outputs to the USB core and DMA.
  output wire [NEP-1:0]  endpoint_irq_out,
  output wire [NEP-1:0]  stall_request_out,
  output wire [NEP-1:0]  nyet_suppress_out,
  output wire [NEP-1:0]  toggle_reset_out,
  output wire [NEP-1:0]  send_packet_out,
  output wire [NEP-1:0]  bank_free_out,
  output wire [NEP-1:0]  dma_pause_out
);
  // APB decode shared by every endpoint.
  wire            acc_wr;
  wire            setup_ph;
  wire [NEP-1:0]  ep_hit;
  wire [NEP*32-1:0] ep_rd;
  reg  [31:0]     rd_word;
  reg             any_hit;
  integer         i;

  // Writes take effect in the access phase; zero wait states.
  assign acc_wr     = psel_in && penable_in && pwrite_in;
  assign setup_ph   = psel_in && !penable_in;
  assign pready_out = 1'b1;
  // Unmapped or misaligned addresses answer with an error.
  assign pslverr_out = psel_in && penable_in && !any_hit;

  // Gather read data and hits from all endpoints.
  always @* begin
    rd_word = 32'h0000_0000;
    any_hit = 1'b0;
    for (i = 0; i < NEP; i = i + 1) begin
      rd_word = rd_word | ep_rd[i*32 +: 32];
      any_hit = any_hit | ep_hit[i];
    end
  end

  // Read data is captured in the setup phase so it is stable for the access.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      prdata_out <= 32'h0000_0000;
    end else if (setup_ph && !pwrite_in) begin
      prdata_out <= rd_word;
    end
  end

  genvar n;
  generate
    for (n = 0; n < NEP; n = n + 1) begin : g_ep
      localparam integer OFS_I = n * 4;
      localparam [11:0]  OFS   = OFS_I[11:0];
      // Address matches for this endpoint.
      wire        aligned;
      wire        hit_cfg;
      wire        hit_sta;
      wire        hit_stclr;
      wire        hit_stset;
      wire        hit_con;
      wire        hit_conset;
      wire        hit_conclr;
      // Decoded endpoint setup.
      wire        ctl;
      wire        iso;
      wire        dir_in;
      wire        rel;
      wire        rise;
      wire        bank_ready;
      wire [1:0]  busy;
      wire [1:0]  cur;
      wire        busy_cond;
      wire [7:0]  clr;
      wire [7:0]  set;
      wire [7:0]  mask;
      wire [7:0]  hw_set;
      wire [7:0]  flags_next;
      wire [31:0] sta_word;
      wire [31:0] con_word;
      wire        send_next;
      wire        free_next;
      // Endpoint state.
      reg  [4:0]  cfg_reg;
      reg  [7:0]  flags_reg;
      reg         force_reg;
      reg  [7:0]  en_reg;
      reg         busy_en_reg;
      reg         pause_reg;
      reg         nyet_reg;
      reg         stall_reg;
      reg         tog_reg;
      reg         txbusy_reg;
      reg         irq_reg;
      reg         dmap_reg;
      reg         send_reg;
      reg         free_reg;

      assign aligned    = paddr_in[1:0] == 2'h0;
      assign hit_cfg    = paddr_in == `USBEF_CFG_BASE + OFS;
      assign hit_sta    = paddr_in == `USBEF_STA_BASE + OFS;
      assign hit_stclr  = paddr_in == `USBEF_STCLR_BASE + OFS;
      assign hit_stset  = paddr_in == `USBEF_STSET_BASE + OFS;
      assign hit_con    = paddr_in == `USBEF_CON_BASE + OFS;
      assign hit_conset = paddr_in == `USBEF_CONSET_BASE + OFS;
      assign hit_conclr = paddr_in == `USBEF_CONCLR_BASE + OFS;
      assign ep_hit[n]  = aligned && (hit_cfg || hit_sta || hit_stclr || hit_stset ||
                                      hit_con || hit_conset || hit_conclr);

      assign ctl    = cfg_reg[1:0] == `USBEF_TYPE_CTRL;
      assign iso    = cfg_reg[1:0] == `USBEF_TYPE_ISO;
      assign dir_in = cfg_reg[`USBEF_CFG_DIR];

      // Software release of a non-control bank; ignored while no bank is held.
      assign rel = acc_wr && hit_conclr && pwdata_in[`USBEF_BANK_REL] &&
                   !ctl && bank_ready;

      // Bank bookkeeping for isochronous, bulk and interrupt endpoints.
      usbef_bank u_bank (
        .clk_in      (clk_in),
        .reset_n_in  (reset_n_in),
        .nbanks_in   (cfg_reg[4:3]),
        .dir_in_in   (dir_in),
        .core_evt_in (!ctl && (dir_in ? in_sent_in[n] : out_rx_in[n])),
        .release_in  (rel),
        .busy_out    (busy),
        .cur_out     (cur),
        .ready_out   (bank_ready),
        .rise_out    (rise)
      );

      // Write-one strobes from the status clear and set words.
      assign clr = (acc_wr && hit_stclr) ? pwdata_in[7:0] : 8'h00;
      assign set = (acc_wr && hit_stset) ? pwdata_in[7:0] : 8'h00;

      // Hardware sources of each flag.
      assign hw_set[`USBEF_IN_READY]  = ctl ? (!txbusy_reg && !flags_reg[`USBEF_IN_READY])
                                            : (dir_in && rise);
      assign hw_set[`USBEF_OUT_RX]    = ctl ? out_rx_in[n]
                                            : (!dir_in && rise);
      assign hw_set[`USBEF_SETUP_RX]  = ctl ? setup_rx_in[n] : underflow_evt_in[n];
      assign hw_set[`USBEF_NAK_OUT]   = nak_out_evt_in[n];
      assign hw_set[`USBEF_NAK_IN]    = nak_in_evt_in[n];
      assign hw_set[`USBEF_OVERFLOW]  = overflow_evt_in[n];
      assign hw_set[`USBEF_STALLED]   = stalled_evt_in[n];
      assign hw_set[`USBEF_SHORT_PKT] = short_evt_in[n];

      // Flags that do not exist for the endpoint type are held at zero.
      assign mask = {5'h1f,
                     ctl || iso,
                     ctl || !dir_in,
                     ctl || dir_in};

      // A set in the same cycle as a clear wins so no event is lost.
      assign flags_next = ((flags_reg & ~clr) | hw_set | set) & mask;

      // Control endpoints hand the bank back when software clears the flag.
      assign free_next = (ctl && flags_reg[`USBEF_SETUP_RX] && clr[`USBEF_SETUP_RX]) ||
                         (ctl && flags_reg[`USBEF_OUT_RX] && clr[`USBEF_OUT_RX]) ||
                         (rel && !dir_in);
      assign send_next = (ctl && flags_reg[`USBEF_IN_READY] && clr[`USBEF_IN_READY]) ||
                         (rel && dir_in);

      // A busy count of zero, all banks free (IN) or all empty (OUT), drives the busy-bank interrupt.
      assign busy_cond = !ctl && (dir_in ? busy == 2'h0 : !bank_ready);

      assign sta_word = {11'h000,
                         bank_ready && !stall_reg && !ctl,
                         cur, busy, 3'h0, force_reg, 4'h0, flags_reg};
      // Bank release reads zero on control endpoints; toggle reset always reads zero.
      assign con_word = {12'h000, stall_reg, 1'b0, nyet_reg, pause_reg, 1'b0,
                         bank_ready && !ctl, 1'b0, busy_en_reg, 4'h0, en_reg};

      // Write-only words have no term here and so read as zero.
      assign ep_rd[n*32 +: 32] = !aligned ? 32'h0000_0000 :
                                 hit_cfg ? {27'h0000000, cfg_reg} :
                                 hit_sta ? sta_word :
                                 hit_con ? con_word : 32'h0000_0000;

      // Status flags and configuration.
      always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          cfg_reg    <= `USBEF_CFG_RESET;
          flags_reg  <= `USBEF_ZERO_RESET;
          force_reg  <= 1'b0;
          txbusy_reg <= 1'b0;
        end else begin
          if (acc_wr && hit_cfg)
            cfg_reg <= pwdata_in[4:0];
          flags_reg <= flags_next;
          // The test trigger stays until the busy-bank interrupt is disabled.
          if (acc_wr && hit_stset && pwdata_in[`USBEF_BUSY_FORCE])
            force_reg <= 1'b1;
          else if (acc_wr && hit_conclr && pwdata_in[`USBEF_BUSY_IRQ_EN])
            force_reg <= 1'b0;
          // Control IN bank is busy from the send until the core reports it gone.
          if (ctl && send_next)
            txbusy_reg <= 1'b1;
          else if (in_sent_in[n])
            txbusy_reg <= 1'b0;
        end
      end

      // Control word: enables and endpoint controls.
      always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          en_reg      <= `USBEF_ZERO_RESET;
          busy_en_reg <= 1'b0;
          pause_reg   <= 1'b0;
          nyet_reg    <= 1'b0;
          stall_reg   <= 1'b0;
          tog_reg     <= 1'b0;
        end else begin
          if (acc_wr && hit_conset) begin
            en_reg      <= en_reg | pwdata_in[7:0];
            busy_en_reg <= busy_en_reg | pwdata_in[`USBEF_BUSY_IRQ_EN];
            pause_reg   <= pause_reg | pwdata_in[`USBEF_DMA_PAUSE];
            nyet_reg    <= nyet_reg | pwdata_in[`USBEF_NYET_SUPP];
          end else if (acc_wr && hit_conclr) begin
            en_reg      <= en_reg & ~pwdata_in[7:0];
            busy_en_reg <= busy_en_reg & ~pwdata_in[`USBEF_BUSY_IRQ_EN];
            pause_reg   <= pause_reg & ~pwdata_in[`USBEF_DMA_PAUSE];
            nyet_reg    <= nyet_reg & ~pwdata_in[`USBEF_NYET_SUPP];
          end
          // A new SETUP cancels a stall so the control pipe can recover.
          if (acc_wr && hit_conset && pwdata_in[`USBEF_STALL_REQ])
            stall_reg <= 1'b1;
          else if ((ctl && setup_rx_in[n]) ||
                   (acc_wr && hit_conclr && pwdata_in[`USBEF_STALL_REQ]))
            stall_reg <= 1'b0;
          // One-cycle pulse to the core; the bit never reads back as one.
          tog_reg <= acc_wr && hit_conset && pwdata_in[`USBEF_TOGGLE_RST];
        end
      end

      // Registered interrupt, DMA pause and bank pulses.
      always @(posedge clk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
          irq_reg  <= 1'b0;
          dmap_reg <= 1'b0;
          send_reg <= 1'b0;
          free_reg <= 1'b0;
        end else begin
          irq_reg  <= (|(flags_reg & en_reg)) ||
                      (busy_en_reg && (busy_cond || force_reg));
          // Bank-tied flags wait for the running transfer; the rest stop it now.
          dmap_reg <= pause_reg &&
                      ((|flags_reg[7:3]) || force_reg ||
                       ((|flags_reg[2:0]) && !dma_busy_in[n]));
          send_reg <= send_next;
          free_reg <= free_next;
        end
      end

      assign endpoint_irq_out[n]  = irq_reg;
      assign stall_request_out[n] = stall_reg;
      assign nyet_suppress_out[n] = nyet_reg;
      assign toggle_reset_out[n]  = tog_reg;
      assign send_packet_out[n]   = send_reg;
      assign bank_free_out[n]     = free_reg;
      assign dma_pause_out[n]     = dmap_reg;
    end
  endgenerate
endmodule // usbef_flags

// [usbef_core_model.sv]
// Behavioural USB core stand-in that turns bench commands into one-cycle event pulses.
`timescale 1ns/10ps
module usbef_core_model #(
  parameter NEP = 8
) (
  // Clock and reset.
  input  wire logic                clk_in,
  input  wire logic                reset_n_in,
  // Command from the bench: event kind and endpoint.
  input  wire logic                cmd_valid_in,
  input  wire logic [3:0]          cmd_kind_in,
  input  wire logic [2:0]          cmd_ep_in,
  // Event pulses; row 0 setup, 1 out, 2 in sent, 3 nak in, 4 nak out, 5 underflow, 6 overflow, 7 stalled, 8 short.
  output logic      [8:0][NEP-1:0] evt_out
);
  // Every pulse lasts exactly one cycle, as the core's own strobes do.
  always @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      evt_out <= '0;
    end else begin
      evt_out <= '0;
      if (cmd_valid_in) begin
        evt_out[cmd_kind_in][cmd_ep_in] <= 1'b1;
      end
    end
  end
endmodule // usbef_core_model

// [usbef_flags_monitor.sv]
// Concurrent checks on the endpoint flag block ports.
`timescale 1ns/10ps
module usbef_flags_monitor #(
  parameter NEP = 8
) (
  input wire logic           clk_in,
  input wire logic           reset_n_in,
  input wire logic           psel_in,
  input wire logic           penable_in,
  input wire logic           pwrite_in,
  input wire logic [11:0]    paddr_in,
  input wire logic [31:0]    pwdata_in,
  input wire logic [31:0]    prdata_out,
  input wire logic [NEP-1:0] setup_rx_in,
  input wire logic [NEP-1:0] stall_request_out,
  input wire logic [NEP-1:0] nyet_suppress_out,
  input wire logic [NEP-1:0] toggle_reset_out,
  input wire logic [NEP-1:0] send_packet_out,
  input wire logic [NEP-1:0] bank_free_out
);
  default clocking dc @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  // Decoded read setups and endpoint 0 control set and clear writes.
  wire rd_s = psel_in & ~penable_in & ~pwrite_in;
  wire wr_a = psel_in & penable_in & pwrite_in;
  wire set0 = wr_a & (paddr_in == 12'h1f0);
  wire clr0 = wr_a & (paddr_in == 12'h220);
  // Read setups of the write-only status words of every endpoint.
  wire rd_clr = rd_s & (paddr_in >= 12'h160) & (paddr_in < 12'h180);
  wire rd_set = rd_s & (paddr_in >= 12'h190) & (paddr_in < 12'h1b0);
  // Stall request set and clear writes on endpoint 0.
  wire stl_set = set0 & pwdata_in[19];
  wire stl_clr = clr0 & pwdata_in[19];

  chk_clear_reads_zero: assert property (rd_clr |=> prdata_out == 32'h0)
    else $error("Status clear word read back nonzero.");
  chk_set_reads_zero: assert property (rd_set |=> prdata_out == 32'h0)
    else $error("Status set word read back nonzero.");
  chk_stall_set: assert property (stl_set |-> ##[1:3] stall_request_out[0])
    else $error("Stall request did not rise after set write.");
  chk_stall_by_setup: assert property (setup_rx_in[0] && !stl_set |-> ##[1:3] !stall_request_out[0])
    else $error("Stall request survived a SETUP.");
  chk_stall_clear: assert property (stl_clr && !setup_rx_in[0] |-> ##[1:3] !stall_request_out[0])
    else $error("Stall request did not fall after clear write.");
  chk_toggle_set: assert property (set0 && pwdata_in[18] |-> ##[1:3] toggle_reset_out[0])
    else $error("Toggle reset pulse missing.");
  chk_toggle_pulse: assert property (toggle_reset_out[0] |=> !toggle_reset_out[0])
    else $error("Toggle reset longer than one cycle.");
  chk_nyet_set: assert property (set0 && pwdata_in[17] |-> ##[1:3] nyet_suppress_out[0])
    else $error("NYET suppression did not rise.");
  chk_nyet_clear: assert property (clr0 && pwdata_in[17] |-> ##[1:3] !nyet_suppress_out[0])
    else $error("NYET suppression did not fall.");
  chk_send_pulse: assert property (send_packet_out[0] |=> !send_packet_out[0])
    else $error("Send packet longer than one cycle.");
  chk_free_pulse: assert property (bank_free_out[0] |=> !bank_free_out[0])
    else $error("Bank free longer than one cycle.");
endmodule // usbef_flags_monitor

bind usbef_flags usbef_flags_monitor #(.NEP(NEP)) u_mon (.clk_in, .reset_n_in, .psel_in, .penable_in, .pwrite_in,
  .paddr_in, .pwdata_in, .prdata_out, .setup_rx_in, .stall_request_out, .nyet_suppress_out, .toggle_reset_out,
  .send_packet_out, .bank_free_out);

// [usbef_flags_tb.sv]
// Self-checking bench for the endpoint flag block over APB.
`timescale 1ns/10ps
`include "usbef_regs.vh"
module usbef_flags_tb;
  logic            clk_in, reset_n_in, psel_in, penable_in, pwrite_in, cv, last_err;
  logic [11:0]     paddr_in;
  logic [31:0]     pwdata_in, q;
  logic [3:0]      ck;
  logic [2:0]      ce;
  logic [7:0]      dma_busy;
  wire  [31:0]     prdata_out;
  wire             pready_out, pslverr_out;
  wire  [8:0][7:0] evt;
  wire  [7:0]      irq, stall, nyet, trst, send, free, pause;
  int              errors, cmp_count, send_cnt, free_cnt, tr_cnt, n;

  usbef_core_model #(.NEP(8)) core (.clk_in(clk_in), .reset_n_in(reset_n_in), .cmd_valid_in(cv),
    .cmd_kind_in(ck), .cmd_ep_in(ce), .evt_out(evt));
  usbef_flags #(.NEP(8)) dut (.clk_in(clk_in), .reset_n_in(reset_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out), .setup_rx_in(evt[0]),
    .out_rx_in(evt[1]), .in_sent_in(evt[2]), .nak_in_evt_in(evt[3]), .nak_out_evt_in(evt[4]),
    .underflow_evt_in(evt[5]), .overflow_evt_in(evt[6]), .stalled_evt_in(evt[7]), .short_evt_in(evt[8]),
    .dma_busy_in(dma_busy), .endpoint_irq_out(irq), .stall_request_out(stall), .nyet_suppress_out(nyet),
    .toggle_reset_out(trst), .send_packet_out(send), .bank_free_out(free), .dma_pause_out(pause));

  // Free-running clock, 10 ns period.
  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end
  // Pulse counters; one-cycle strobes are easy to miss by polling.
  always @(posedge clk_in) begin
    if (|send === 1'b1) send_cnt++;
    if (|free === 1'b1) free_cnt++;
    if (trst[0] === 1'b1) tr_cnt++;
  end
  function automatic [11:0] ad(input [11:0] base, input int ep);
    ad = base + 12'(ep * 4);
  endfunction
  // One APB transfer; held until pready is seen high.
  task automatic apb(input logic w, input [11:0] a, input [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1; penable_in <= 1'b0; pwrite_in <= w; paddr_in <= a; pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    q = prdata_out;
    last_err = pslverr_out;
    psel_in <= 1'b0; penable_in <= 1'b0;
  endtask
  task automatic w3(input [11:0] a, input [31:0] d);
    apb(1'b1, a, d);
    repeat (3) @(posedge clk_in);
  endtask
  task automatic chk(input string nm, input [31:0] e, input [31:0] g);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic rdc(input string nm, input [11:0] a, input [31:0] m, input [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, e, q & m);
  endtask
  task automatic evt_go(input [3:0] k, input [2:0] ep);
    @(posedge clk_in);
    cv <= 1'b1; ck <= k; ce <= ep;
    @(posedge clk_in);
    cv <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  task automatic wrap_up;
    $display("errors=%0d comparisons=%0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Watchdog, far beyond the few hundred cycles the sequence needs.
  initial begin
    #200us;
    errors++;
    wrap_up;
  end
  // Main sequence.
  initial begin
    {psel_in, penable_in, pwrite_in, cv, reset_n_in} = '0;
    {paddr_in, pwdata_in, ck, ce, dma_busy} = '0;
    repeat (8) @(posedge clk_in);
    reset_n_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    rdc("cfg0", ad(`USBEF_CFG_BASE, 0), 32'h1f, 32'h08);
    rdc("in_ready0", ad(`USBEF_STA_BASE, 0), 32'h1, 32'h1);
    w3(ad(`USBEF_CON_BASE, 0), 32'h000f_ffff);
    rdc("con0", ad(`USBEF_CON_BASE, 0), 32'hffff_ffff, 32'h0);
    rdc("unmapped", 12'h3fc, 32'hffff_ffff, 32'h0);
    chk("slverr", 1, last_err);
    w3(ad(`USBEF_CONSET_BASE, 0), 32'h4);
    evt_go(0, 0);
    rdc("setup0", ad(`USBEF_STA_BASE, 0), 32'h4, 32'h4);
    chk("irq0", 1, irq[0]);
    n = free_cnt;
    w3(ad(`USBEF_STCLR_BASE, 0), 32'h4);
    chk("free setup", n + 1, free_cnt);
    rdc("setup0 clr", ad(`USBEF_STA_BASE, 0), 32'h4, 32'h0);
    chk("irq0 off", 0, irq[0]);
    w3(ad(`USBEF_CONCLR_BASE, 0), 32'h4);
    w3(ad(`USBEF_STSET_BASE, 0), 32'h4);
    chk("irq0 masked", 0, irq[0]);
    w3(ad(`USBEF_STCLR_BASE, 0), 32'h4);
    fork
      w3(ad(`USBEF_STCLR_BASE, 0), 32'h2);
      evt_go(1, 0);
    join
    rdc("out0 kept", ad(`USBEF_STA_BASE, 0), 32'h2, 32'h2);
    n = free_cnt;
    w3(ad(`USBEF_STCLR_BASE, 0), 32'h2);
    chk("free out0", n + 1, free_cnt);
    n = send_cnt;
    w3(ad(`USBEF_STCLR_BASE, 0), 32'h1);
    chk("send0", n + 1, send_cnt);
    evt_go(2, 0);
    rdc("in_ready0 back", ad(`USBEF_STA_BASE, 0), 32'h1, 32'h1);
    w3(ad(`USBEF_CFG_BASE, 1), 32'h0a);
    rdc("ep1 idle", ad(`USBEF_STA_BASE, 1), 32'h7, 32'h0);
    evt_go(1, 1);
    rdc("out1", ad(`USBEF_STA_BASE, 1), 32'h2, 32'h2);
    rdc("rel1", ad(`USBEF_CON_BASE, 1), 32'h4000, 32'h4000);
    n = free_cnt;
    w3(ad(`USBEF_STCLR_BASE, 1), 32'h2);
    rdc("rel1 kept", ad(`USBEF_CON_BASE, 1), 32'h4000, 32'h4000);
    chk("no free1", n, free_cnt);
    w3(ad(`USBEF_CONCLR_BASE, 1), 32'h4000);
    chk("free1", n + 1, free_cnt);
    rdc("rel1 off", ad(`USBEF_CON_BASE, 1), 32'h4000, 32'h0);
    w3(ad(`USBEF_CFG_BASE, 2), 32'h0e);
    rdc("ep2 flags", ad(`USBEF_STA_BASE, 2), 32'h3, 32'h1);
    rdc("rel2", ad(`USBEF_CON_BASE, 2), 32'h4000, 32'h4000);
    n = send_cnt;
    w3(ad(`USBEF_STCLR_BASE, 2), 32'h1);
    chk("no send2", n, send_cnt);
    w3(ad(`USBEF_CONCLR_BASE, 2), 32'h4000);
    chk("send2", n + 1, send_cnt);
    // Two-bank bulk OUT: releasing the first full bank re-arms the flag for the second.
    w3(ad(`USBEF_CFG_BASE, 6), 32'h12);
    evt_go(1, 6);
    evt_go(1, 6);
    w3(ad(`USBEF_STCLR_BASE, 6), 32'h2);
    w3(ad(`USBEF_CONCLR_BASE, 6), 32'h4000);
    rdc("ep6 next", ad(`USBEF_STA_BASE, 6), 32'h1f_0002, 32'h15_0002);
    rdc("rel6 next", ad(`USBEF_CON_BASE, 6), 32'h4000, 32'h4000);
    w3(ad(`USBEF_CFG_BASE, 3), 32'h09);
    evt_go(5, 3);
    rdc("underflow3", ad(`USBEF_STA_BASE, 3), 32'h4, 32'h4);
    w3(ad(`USBEF_STSET_BASE, 4), 32'h10ff);
    rdc("set4", ad(`USBEF_STA_BASE, 4), 32'h10ff, 32'h10ff);
    rdc("set4 rd", ad(`USBEF_STSET_BASE, 4), 32'hffff_ffff, 32'h0);
    w3(ad(`USBEF_STCLR_BASE, 4), 32'h0);
    rdc("clr4 zero", ad(`USBEF_STA_BASE, 4), 32'hff, 32'hff);
    w3(ad(`USBEF_STCLR_BASE, 4), 32'hfe);
    rdc("clr4", ad(`USBEF_STA_BASE, 4), 32'hfe, 32'h0);
    rdc("clr4 rd", ad(`USBEF_STCLR_BASE, 4), 32'hffff_ffff, 32'h0);
    w3(ad(`USBEF_CONSET_BASE, 0), 32'h0008_0000);
    chk("stall set", 1, stall[0]);
    evt_go(0, 0);
    chk("stall setup", 0, stall[0]);
    w3(ad(`USBEF_CONSET_BASE, 0), 32'h0008_0000);
    w3(ad(`USBEF_CONCLR_BASE, 0), 32'h0008_0000);
    chk("stall clr", 0, stall[0]);
    n = tr_cnt;
    w3(ad(`USBEF_CONSET_BASE, 0), 32'h0004_0000);
    chk("toggle", n + 1, tr_cnt);
    rdc("toggle rd", ad(`USBEF_CON_BASE, 0), 32'h0004_0000, 32'h0);
    w3(ad(`USBEF_CONSET_BASE, 0), 32'h0002_0000);
    chk("nyet on", 1, nyet[0]);
    w3(ad(`USBEF_CONCLR_BASE, 0), 32'h0002_0000);
    chk("nyet off", 0, nyet[0]);
    w3(ad(`USBEF_STCLR_BASE, 5), 32'h1);
    w3(ad(`USBEF_CONSET_BASE, 5), 32'h0001_0000);
    chk("pause idle", 0, pause[5]);
    evt_go(3, 5);
    chk("pause nak", 1, pause[5]);
    w3(ad(`USBEF_STCLR_BASE, 5), 32'h10);
    chk("pause ack", 0, pause[5]);
    dma_busy[5] <= 1'b1;
    evt_go(0, 5);
    chk("pause busy", 0, pause[5]);
    dma_busy[5] <= 1'b0;
    repeat (3) @(posedge clk_in);
    chk("pause next", 1, pause[5]);
    w3(ad(`USBEF_CONCLR_BASE, 5), 32'h0001_0000);
    chk("pause off", 0, pause[5]);
    wrap_up;
  end
endmodule // usbef_flags_tb
